/* File: src/dtc_defines.svh */
// Purpose: Constants for the dual counter/timer block
// Assumes: Byte-wide registers, one per aligned 32-bit Wishbone word
// Notes: Offsets are byte addresses
// Functional notes
// R01: Each 16-bit count read as two bytes
// R02: Four modes per timer, independently configured
// R03: Mode 0 is 13 bits: high byte, low[4:0]
// R04: Software ignores low byte bits 7 to 5
// R05: 13-bit wrap sets overflow flag, requests interrupt
// R06: Counter mode counts count-pin falling edges
// R07: Timer mode uses system clock or prescaler
// R08: Count only when run and gate allow
// R09: Per-timer gate polarity bit sets active level
// R10: Run bit never clears the count
// R11: Timer 1 mirrors Timer 0 with own bits; the code shares the prescaler scale field clkCtlR[1:0] between both timers
// R12: Overflow interrupt only when its enable set
// R13: Pins synchronised, each falling edge counts once
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

`define DTC_ADR_CONTROL 8'h00
`define DTC_ADR_MODE 8'h04
`define DTC_ADR_LOW0 8'h08
`define DTC_ADR_LOW1 8'h0C
`define DTC_ADR_HIGH0 8'h10
`define DTC_ADR_HIGH1 8'h14
`define DTC_ADR_CLKCTL 8'h18
`define DTC_ADR_EXTCFG 8'h1C
`define DTC_ADR_IRQEN 8'h20
`define DTC_ADR_STATUS 8'h24

// Control register: run and flag bit of each timer
`define DTC_CTL_RUN0 4
`define DTC_CTL_FLAG0 5
`define DTC_CTL_RUN1 6
`define DTC_CTL_FLAG1 7
// Mode register: one nibble per timer
`define DTC_MODE_NIB 4
`define DTC_MODE_CT 2
`define DTC_MODE_GATE 3
// Clock control: scale field and system clock selects
`define DTC_CKC_SYS0 3
`define DTC_CKC_SYS1 4
// Ext input config: gate polarity bits, 1 = active high
`define DTC_EXT_POL0 3
`define DTC_EXT_POL1 7
// Prescaler width; scale code k divides by 2^(k+2)
`define DTC_PRE_W 5
`define DTC_PRE_BASE 2

`define DTC_RST_BYTE 8'h00
`define DTC_BYTE_ONES 8'hFF
`define DTC_LOW5_ONES 5'h1F

`endif

/* File: src/dtc_pkg.sv */
// Purpose: Types for the dual counter/timer block
// Assumes: Nothing
// Notes: Mode codes follow the two mode-select bits
package dtc_pkg;

  typedef enum logic [1:0]
  {
    DTC_MODE13 = 2'h0,
    DTC_MODE16 = 2'h1,
    DTC_MODE8R = 2'h2,
    DTC_MODESPLIT = 2'h3
  } dtc_mode_type;

endpackage : dtc_pkg

/* File: src/dtc_timer.sv */
// Purpose: Two counter/timers with Wishbone registers and one interrupt
// Assumes: Pins are asynchronous to core_clk; classic Wishbone master
// Notes: Ack comes one edge after request; write commits at that edge
`include "dtc_defines.svh"

module dtc_timer
  import dtc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [ADDR_W-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire logic countPin0,
  input wire logic countPin1,
  input wire logic gatePin0,
  input wire logic gatePin1,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Count step and wrap detect per mode

  function automatic logic [15:0] dtcStep
  (
    input logic [15:0] v,
    input dtc_mode_type m
  );
    logic [15:0] r;
    r = v;
    case (m)
      DTC_MODE13:
      begin
        r[4:0] = v[4:0] + 5'h01;
        if (v[4:0] == `DTC_LOW5_ONES)
          r[15:8] = v[15:8] + 8'h01;
      end
      DTC_MODE16: r = v + 16'h0001;
      DTC_MODE8R:
        r[7:0] = (v[7:0] == `DTC_BYTE_ONES) ? v[15:8] : v[7:0] + 8'h01;
      default: r[7:0] = v[7:0] + 8'h01;
    endcase
    return r;
  endfunction : dtcStep

  function automatic logic dtcWraps
  (
    input logic [15:0] v,
    input dtc_mode_type m
  );
    logic w;
    case (m)
      DTC_MODE13:
        w = (v[15:8] == `DTC_BYTE_ONES) && (v[4:0] == `DTC_LOW5_ONES);
      DTC_MODE16: w = (v == 16'hFFFF);
      default: w = (v[7:0] == `DTC_BYTE_ONES);
    endcase
    return w;
  endfunction : dtcWraps

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic ackR;
  logic [31:0] datOutR;
  logic irqR;
  logic [15:0] countR [2];
  logic [1:0] runR;
  logic [1:0] flagR;
  logic [7:0] modeR;
  logic [7:0] clkCtlR;
  logic [7:0] extCfgR;
  logic [1:0] irqEnR;
  logic [2:0] cntSyncR [2];
  logic [1:0] gateSyncR [2];
  logic [`DTC_PRE_W-1:0] preR;

  logic access;
  logic wrByte;
  logic [7:0] wrData;
  logic [7:0] rdByte;
  logic [1:0] wrLow;
  logic [1:0] wrHigh;
  logic [1:0] fallEdge;
  logic [1:0] gateOk;
  logic [1:0] countEn;
  logic [1:0] tick;
  logic [1:0] wrapNow;
  logic [1:0] sysSel;
  logic [1:0] gatePol;
  logic preTick;
  dtc_mode_type tMode [2];

  assign wbAck = ackR;
  assign wbDatOut = datOutR;
  assign irq = irqR;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  assign access = wbCyc && wbStb && !ackR;
  assign wrByte = access && wbWe && wbSel[0];
  assign wrData = wbDatIn[7:0];
  assign wrLow[0] = wrByte && (wbAdr == `DTC_ADR_LOW0);
  assign wrLow[1] = wrByte && (wbAdr == `DTC_ADR_LOW1);
  assign wrHigh[0] = wrByte && (wbAdr == `DTC_ADR_HIGH0);
  assign wrHigh[1] = wrByte && (wbAdr == `DTC_ADR_HIGH1);

  always_comb
  begin
    case (wbAdr)
      `DTC_ADR_CONTROL:
        rdByte = {flagR[1], runR[1], flagR[0], runR[0], 4'h0};
      `DTC_ADR_MODE: rdByte = modeR;
      `DTC_ADR_LOW0: rdByte = countR[0][7:0]; // [R01]
      `DTC_ADR_LOW1: rdByte = countR[1][7:0];
      `DTC_ADR_HIGH0: rdByte = countR[0][15:8];
      `DTC_ADR_HIGH1: rdByte = countR[1][15:8];
      `DTC_ADR_CLKCTL: rdByte = clkCtlR;
      `DTC_ADR_EXTCFG: rdByte = extCfgR;
      `DTC_ADR_IRQEN: rdByte = {6'h00, irqEnR};
      `DTC_ADR_STATUS: rdByte = {6'h00, flagR};
      default: rdByte = `DTC_RST_BYTE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ackR <= 1'b0;
      datOutR <= 32'h0000_0000;
    end
    else
    begin
      ackR <= access;
      if (access && !wbWe)
        datOutR <= {24'h00_0000, rdByte};
    end
  end

  // Configuration registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      runR <= 2'h0;
      modeR <= `DTC_RST_BYTE;
      clkCtlR <= `DTC_RST_BYTE;
      extCfgR <= `DTC_RST_BYTE;
      irqEnR <= 2'h0;
    end
    else if (wrByte)
    begin
      case (wbAdr)
        `DTC_ADR_CONTROL:
        begin
          runR[0] <= wrData[`DTC_CTL_RUN0];
          runR[1] <= wrData[`DTC_CTL_RUN1];
        end
        `DTC_ADR_MODE: modeR <= wrData; // [R02]
        `DTC_ADR_CLKCTL: clkCtlR <= wrData;
        `DTC_ADR_EXTCFG: extCfgR <= wrData;
        `DTC_ADR_IRQEN: irqEnR <= wrData[1:0]; // [R12]
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and prescaler

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cntSyncR[0] <= 3'h7;
      cntSyncR[1] <= 3'h7;
      gateSyncR[0] <= 2'h0;
      gateSyncR[1] <= 2'h0;
    end
    else
    begin
      cntSyncR[0] <= {cntSyncR[0][1:0], countPin0}; // [R13]
      cntSyncR[1] <= {cntSyncR[1][1:0], countPin1};
      gateSyncR[0] <= {gateSyncR[0][0], gatePin0};
      gateSyncR[1] <= {gateSyncR[1][0], gatePin1};
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      preR <= '0;
    else
      preR <= preR + 1'b1;
  end

  // Scale code k ticks once every 2^(k+2) cycles
  always_comb
  begin
    preTick = 1'b1;
    for (int i = 0; i < `DTC_PRE_W; i++)
    begin
      if (i < int'(clkCtlR[1:0]) + `DTC_PRE_BASE && !preR[i])
        preTick = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count enable and tick selection

  assign sysSel = {clkCtlR[`DTC_CKC_SYS1], clkCtlR[`DTC_CKC_SYS0]};
  assign gatePol = {extCfgR[`DTC_EXT_POL1], extCfgR[`DTC_EXT_POL0]};

  always_comb
  begin
    for (int t = 0; t < 2; t++)
    begin
      tMode[t] = dtc_mode_type'(modeR[t*`DTC_MODE_NIB +: 2]);
      fallEdge[t] = cntSyncR[t][2] && !cntSyncR[t][1]; // [R13]
      gateOk[t] = !modeR[t*`DTC_MODE_NIB + `DTC_MODE_GATE]
        || (gateSyncR[t][1] == gatePol[t]); // [R09]
      countEn[t] = runR[t] && gateOk[t]; // [R08] [R11]
      if (modeR[t*`DTC_MODE_NIB + `DTC_MODE_CT])
        tick[t] = countEn[t] && fallEdge[t]; // [R06]
      else
        tick[t] = countEn[t] && (sysSel[t] || preTick); // [R07]
      wrapNow[t] = tick[t] && dtcWraps(countR[t], tMode[t]); // [R05]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counters: software writes win over a count step

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      countR[0] <= 16'h0000;
      countR[1] <= 16'h0000;
    end
    else
    begin
      for (int t = 0; t < 2; t++)
      begin
        if (wrLow[t])
          countR[t][7:0] <= wrData; // [R01] [R10]
        else if (wrHigh[t])
          countR[t][15:8] <= wrData;
        else if (tick[t])
          countR[t] <= dtcStep(countR[t], tMode[t]); // [R03] [R11]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overflow flags, cleared by writing one; a new wrap wins

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      flagR <= 2'h0;
    end
    else
    begin
      for (int t = 0; t < 2; t++)
      begin
        if (wrapNow[t])
          flagR[t] <= 1'b1; // [R05]
        else if (wrByte && (wbAdr == `DTC_ADR_STATUS) && wrData[t])
          flagR[t] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irqR <= 1'b0;
    else
      irqR <= |(flagR & irqEnR); // [R12]
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence seqNoWrite0;
    !wrLow[0] && !wrHigh[0];
  endsequence

  sequence seqMode0Step;
    seqNoWrite0 ##0 tick[0] && tMode[0] == DTC_MODE13;
  endsequence

  chk_ack_pulse: assert property (ackR |=> !ackR) // [R01]
    else $error("ack held longer than one cycle");

  chk_wrap_flag: assert property ( // [R05]
    seqMode0Step ##0 countR[0] == 16'hFF1F |=> flagR[0]
      && countR[0][15:8] == 8'h00 && countR[0][4:0] == 5'h00)
    else $error("13-bit wrap did not clear count and set flag");

  chk_mode0_step: assert property ( // [R03]
    seqMode0Step ##0 countR[0][4:0] != 5'h1F |=>
      countR[0][4:0] == $past(countR[0][4:0]) + 5'h01
      && $stable(countR[0][15:8]) && $stable(countR[0][7:5]))
    else $error("13-bit step wrong");

  chk_hold_off: assert property ( // [R08]
    seqNoWrite0 ##0 (!runR[0] || !gateOk[0]) |=> $stable(countR[0]))
    else $error("timer 0 moved while disabled");

  chk_edge_count: assert property ( // [R06]
    seqNoWrite0 ##0 (modeR[`DTC_MODE_CT] && runR[0] && gateOk[0]
      && !fallEdge[0]) |=> $stable(countR[0]))
    else $error("counter moved without a pin edge");

  chk_edge_once: assert property (fallEdge[0] |=> !fallEdge[0]) // [R13]
    else $error("one pin edge counted twice");

  chk_sysclk_rate: assert property ( // [R07]
    !modeR[`DTC_MODE_CT] && sysSel[0] && countEn[0]
      |-> tick[0])
    else $error("system clock select did not tick");

  chk_gate_pol: assert property ( // [R09]
    runR[0] && modeR[`DTC_MODE_GATE]
      && gateSyncR[0][1] != gatePol[0] |-> !tick[0])
    else $error("gate inactive level let timer count");

  chk_run_keeps: assert property ( // [R10]
    $rose(runR[0]) && $past(!wrLow[0] && !wrHigh[0]) && !tick[0]
      |-> countR[0] == $past(countR[0]))
    else $error("setting run altered the count");

  chk_irq_gate: assert property ( // [R12]
    ##1 irqR == $past(|(flagR & irqEnR)))
    else $error("interrupt not tracking enabled flags");

  chk_t1_wrap: assert property ( // [R11]
    wrapNow[1] |=> flagR[1])
    else $error("timer 1 wrap missed its flag");

  chk_indep_mode: assert property ( // [R02]
    !wrLow[1] && !wrHigh[1] && !tick[1] |=> $stable(countR[1]))
    else $error("timer 1 moved without its own tick");

endmodule : dtc_timer

/* File: testbench/dtc_pin_model.sv */
// Purpose: Drives the external count and gate pins of both timers
// Assumes: The bench calls the tasks just after a rising clock edge
// Notes: Count pins idle high; each pulse level lasts three cycles
module dtc_pin_model
(
  input wire logic core_clk,
  output logic countPin0,
  output logic countPin1,
  output logic gatePin0,
  output logic gatePin1
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] cnt_r;
  logic [1:0] gate_r;

  assign countPin0 = cnt_r[0];
  assign countPin1 = cnt_r[1];
  assign gatePin0 = gate_r[0];
  assign gatePin1 = gate_r[1];

  initial
  begin
    cnt_r = 2'h3;
    gate_r = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Falling edges, each level held long enough for the synchroniser
  task automatic pulse(input int t, input int n);
    repeat (n)
    begin
      cnt_r[t] <= 1'b0;
      repeat (3) @(posedge core_clk);
      cnt_r[t] <= 1'b1;
      repeat (3) @(posedge core_clk);
    end
  endtask : pulse

  // Level settles through the synchroniser before returning
  task automatic gate(input int t, input logic v);
    gate_r[t] <= v;
    repeat (4) @(posedge core_clk);
  endtask : gate
endmodule : dtc_pin_model

/* File: testbench/dtc_timer_tb.sv */
// Purpose: Self-checking bench for the dual counter/timer
// Assumes: Pin model drives count and gate pins
// Notes: Wishbone accesses end just after a rising edge
module dtc_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk;
  logic rst;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatIn;
  logic [31:0] wbDatOut;
  logic wbAck;
  logic countPin0;
  logic countPin1;
  logic gatePin0;
  logic gatePin1;
  logic irq;
  int fails;
  int checked;
  int t;
  int n;
  int e;
  logic p;
  logic [7:0] l;
  logic [7:0] h;
  logic [12:0] v;
  logic [31:0] q;
  logic [15:0] x;

  dtc_timer i_dtc_timer
  (
    .core_clk(core_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut), .wbAck(wbAck), .countPin0(countPin0),
    .countPin1(countPin1), .gatePin0(gatePin0), .gatePin1(gatePin1),
    .irq(irq)
  );

  dtc_pin_model i_dtc_pin_model
  (
    .core_clk(core_clk), .countPin0(countPin0), .countPin1(countPin1),
    .gatePin0(gatePin0), .gatePin1(gatePin1)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] x,
    input logic [31:0] g);
    checked++;
    if (g !== x)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", s, x, g);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  // One classic cycle; ack and read data taken at a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] r);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatIn <= {24'h0, d};
    @(posedge core_clk);
    while (wbAck !== 1'b1) @(posedge core_clk);
    r = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge core_clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 8'h00, r);
  endtask : rd

  // 13-bit count of a timer, upper low-byte bits ignored
  task automatic getc(input int k, output logic [12:0] c);
    logic [31:0] lo;
    logic [31:0] hi;
    rd(8'(8'h08 + 4 * k), lo);
    rd(8'(8'h10 + 4 * k), hi);
    c = {hi[7:0], lo[4:0]};
  endtask : getc

  function automatic logic [12:0] exp13(logic [7:0] hb, logic [7:0] lb,
    int k);
    return {hb, lb[4:0]} + 13'(k);
  endfunction : exp13

  // Count after k ticks in modes 1 to 3
  function automatic logic [15:0] expm(int m, logic [7:0] hb,
    logic [7:0] lb, int k);
    logic [15:0] c;
    c = {hb, lb};
    for (int i = 0; i < k; i++)
    begin
      if (m == 1)
        c = c + 16'h0001;
      else if (m == 2)
        c[7:0] = (c[7:0] == 8'hFF) ? hb : c[7:0] + 8'h01;
      else
        c[7:0] = c[7:0] + 8'h01;
    end
    return c;
  endfunction : expm

  task automatic pin_chk(input string s, input logic x);
    @(negedge core_clk);
    chk(s, {31'h0, x}, {31'h0, irq});
    @(posedge core_clk);
  endtask : pin_chk

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fails = 0;
    checked = 0;
    rst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'hF;
    wbDatIn = 32'h0;
    void'($urandom(32'h77E1));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    wr(8'h28, 8'hFF);
    for (int a = 0; a <= 8'h28; a += 4)
    begin
      rd(8'(a), q);
      chk("reset reg", 32'h0, q);
    end
    $display("test reset done");
    wr(8'h04, 8'hCC);
    for (int i = 0; i < 6; i++)
    begin
      t = i % 2;
      l = 8'($urandom);
      h = 8'($urandom);
      n = 1 + $urandom % 6;
      p = 1'($urandom);
      wr(8'h1C, {p, 3'h0, p, 3'h0});
      i_dtc_pin_model.gate(t, !p);
      wr(8'(8'h08 + 4 * t), l);
      wr(8'(8'h10 + 4 * t), h);
      wr(8'h00, 8'(8'h10 << (2 * t)));
      i_dtc_pin_model.pulse(t, 2);
      getc(t, v);
      chk("gated count", exp13(h, l, 0), v);
      i_dtc_pin_model.gate(t, p);
      i_dtc_pin_model.pulse(t, n);
      getc(t, v);
      chk("pin count", exp13(h, l, n), v);
      wr(8'h00, 8'h00);
      i_dtc_pin_model.pulse(t, 2);
      getc(t, v);
      chk("stopped count", exp13(h, l, n), v);
    end
    $display("test counter done");
    wr(8'h24, 8'h03);
    wr(8'h04, 8'h00);
    wr(8'h18, 8'h18);
    wr(8'h20, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      wr(8'(8'h08 + 4 * k), 8'h1C);
      wr(8'(8'h10 + 4 * k), 8'hFF);
    end
    wr(8'h00, 8'h50);
    repeat (20) @(posedge core_clk);
    wr(8'h00, 8'h00);
    rd(8'h00, q);
    chk("control flags", 32'hA0, q);
    rd(8'h24, q);
    chk("status", 32'h3, q);
    rd(8'h10, q);
    chk("high after wrap", 32'h0, q);
    pin_chk("irq set", 1'b1);
    wr(8'h24, 8'h01);
    pin_chk("irq masked", 1'b0);
    wr(8'h24, 8'h02);
    rd(8'h24, q);
    chk("status clear", 32'h0, q);
    $display("test overflow done");
    wr(8'h20, 8'h00);
    for (int s = 0; s < 5; s++)
    begin
      wr(8'h08, 8'h00);
      wr(8'h10, 8'h00);
      wr(8'h18, s == 4 ? 8'h08 : 8'(s));
      wr(8'h00, 8'h10);
      repeat (64) @(posedge core_clk);
      wr(8'h00, 8'h00);
      getc(0, v);
      e = 67 / (s == 4 ? 1 : 4 << s);
      chk("ticks", 32'h1, 32'(v >= e - 1 && v <= e + 1));
    end
    $display("test prescale done");
    wr(8'h18, 8'h10);
    for (int m = 1; m < 4; m++)
    begin
      l = 8'hF8 + 8'($urandom % 8);
      h = 8'($urandom);
      wr(8'h04, 8'(m << 4));
      wr(8'h0C, l);
      wr(8'h14, h);
      wr(8'h00, 8'h40);
      repeat (5) @(posedge core_clk);
      wr(8'h00, 8'h00);
      x = expm(m, h, l, 8);
      rd(8'h0C, q);
      chk("mode low", {24'h0, x[7:0]}, q);
      rd(8'h14, q);
      chk("mode high", {24'h0, x[15:8]}, q);
    end
    $display("test modes done");
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    $display("BAD watchdog expected done seen hang");
    print_verdict();
  end
endmodule : dtc_timer_tb
